// ==== dv/csd_host_model.sv ====
`timescale 1ns/10ps
// host that drives the setting pin as a level or as a pwm wave
module csd_host_model (
   // control from the bench
   input  wire logic        clk_in,
   input  wire logic        pwm_en_in,
   input  wire logic        level_in,
   input  wire logic [15:0] hi_in,
   input  wire logic [15:0] per_in,
   // setting pin
   output logic             pin_out
);
   int unsigned cnt;
   logic        en_s;
   logic        lvl_s;
   logic [15:0] hi_s;
   logic [15:0] per_s;
   // controls taken at the rising edge, away from the bench's falling-edge updates
   always @(posedge clk_in) begin
      en_s  <= pwm_en_in;
      lvl_s <= level_in;
      hi_s  <= hi_in;
      per_s <= per_in;
   end
   // period counter, pin high for hi_s of every per_s cycles
   always @(negedge clk_in) begin
      if (en_s) begin
         cnt = (cnt + 1 >= per_s) ? 0 : cnt + 1;
         pin_out <= (cnt < hi_s);
      end else begin
         cnt = 0;
         pin_out <= lvl_s;
      end
   end
endmodule

// ==== dv/csd_top_sva.sv ====
`timescale 1ns/10ps
// port checks for the charge setting decoder
module csd_top_sva
   import csd_pkg::*;
#(
   parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // watched inputs
   input wire logic        adapter_present_in,
   input wire logic        input_over_limit_in,
   input wire logic        voltage_adjust_rail_in,
   input wire logic        charger_ready_in,
   input wire logic [11:0] setting_level_mv_in,
   // watched outputs
   input wire logic [7:0]  setpoint_out,
   input wire csd_status_t status_out,
   input wire logic        boost_supply_refresh_out
);
   localparam int RP = REFRESH_CYCLES;
   logic [31:0] gap_q, gap_d;
   logic        seen_q, seen_d;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // cycles since the last refresh pulse while the adapter stays
   always_comb begin
      gap_d = gap_q + 32'h1;
      seen_d = seen_q;
      if (!adapter_present_in) begin
         gap_d = 32'h0;
         seen_d = 1'b0;
      end else if (boost_supply_refresh_out) begin
         gap_d = 32'h0;
         seen_d = 1'b1;
      end
   end
   always_ff @(posedge clk_in) begin
      gap_q <= rst_in ? 32'h0 : gap_d;
      seen_q <= rst_in ? 1'b0 : seen_d;
   end
   AST_REFRESH_DUE: assert property (gap_q <= RP + 4)
      else $error("refresh pulse overdue");
   AST_REFRESH_GAP: assert property (
      boost_supply_refresh_out && seen_q |-> gap_q >= RP - 2)
      else $error("refresh pulses too close");
   AST_NO_REFRESH: assert property (
      !adapter_present_in [*3] |-> !boost_supply_refresh_out)
      else $error("refresh pulse without adapter");
   AST_PWM_FS: assert property (
      status_out.pwm_mode |-> status_out.full_scale_mv == FS_PWM_MV)
      else $error("wrong pwm full scale");
   AST_ANALOG_FS: assert property (
      status_out.full_scale_mv != 8'h00 && !status_out.pwm_mode
      |-> status_out.full_scale_mv == FS_ANALOG_MV)
      else $error("wrong analog full scale");
   AST_ANALOG_OFF: assert property (
      setting_level_mv_in <= ENABLE_MV && !status_out.pwm_mode
      |=> !status_out.charge_enable || status_out.pwm_mode)
      else $error("charging at low analog level");
   AST_ANALOG_CODE: assert property (
      status_out.full_scale_mv == FS_ANALOG_MV [*2] |-> setpoint_out == CODE_RST)
      else $error("setpoint not zero in analog mode");
   AST_LOOP_INPUT: assert property (
      input_over_limit_in |=> status_out.loop_sel == CSD_LOOP_INPUT)
      else $error("input loop not selected");
   AST_DEFAULT_V: assert property (
      $rose(voltage_adjust_rail_in) |=> status_out.default_voltage)
      else $error("default cell voltage not selected");
   AST_MODE_HOLD: assert property (
      charger_ready_in && $past(charger_ready_in) && $past(charger_ready_in, 2)
      && status_out.full_scale_mv != 8'h00
      |=> $stable(status_out.pwm_mode))
      else $error("mode changed after decision");
   // main scenarios reached
   cover property (status_out.pwm_mode && status_out.charge_enable);
   cover property (status_out.full_scale_mv == FS_ANALOG_MV && status_out.charge_enable);
   cover property (boost_supply_refresh_out && seen_q);
endmodule
bind csd_top csd_top_sva #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_sva (
   .clk_in, .rst_in, .adapter_present_in, .input_over_limit_in, .voltage_adjust_rail_in,
   .charger_ready_in, .setting_level_mv_in, .setpoint_out, .status_out,
   .boost_supply_refresh_out);

// ==== dv/test_charge_setting_decoder.sv ====
`timescale 1ns/10ps
// self-checking bench for the charge setting decoder
module test_charge_setting_decoder import csd_pkg::*;;
   localparam int unsigned REF = 50;
   logic        clk_in = 0, rst_in = 1, ready = 0, adp = 0, at_sp = 0, over = 0;
   logic        rail = 0, pwm_en = 0, lvl = 0, pin, refresh, look = 0;
   logic [15:0] hi = 16'h0000, per = 16'h0190;
   logic [11:0] mv = 12'h000;
   logic [11:0] lv [4] = '{12'h019, 12'h01a, 12'h02d, 12'h02e};
   logic [7:0]  setpoint;
   logic [17:0] n;
   logic [17:0] notes[$];
   csd_status_t status;
   int          err_count = 0, n_tests = 0, pulses = 0, seed = 10381, c;
   initial forever #5 clk_in = ~clk_in;
   csd_host_model host (.clk_in(clk_in), .pwm_en_in(pwm_en), .level_in(lvl), .hi_in(hi),
      .per_in(per), .pin_out(pin));
   csd_top #(.DETECT_CYCLES(200), .REFRESH_CYCLES(REF), .PWM_MAX_PERIOD(2000)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .charger_ready_in(ready),
      .adapter_present_in(adp), .battery_at_setpoint_in(at_sp), .input_over_limit_in(over),
      .voltage_adjust_rail_in(rail), .charge_setting_input_in(pin),
      .setting_level_mv_in(mv), .setpoint_out(setpoint), .status_out(status),
      .boost_supply_refresh_out(refresh));
   function automatic logic [15:0] st(input logic p, input logic e, input logic [7:0] f);
      csd_status_t s;
      s.pwm_mode = p;
      s.charge_enable = e;
      s.default_voltage = rail;
      s.loop_sel = over ? CSD_LOOP_INPUT : at_sp ? CSD_LOOP_VOLTAGE : CSD_LOOP_CURRENT;
      s.full_scale_mv = f;
      return {3'h0, s};
   endfunction
   task automatic compare(input logic [15:0] e, input logic [15:0] a);
      n_tests++;
      if (a !== e) begin
         err_count++;
         $display("mismatch at %0t: expected %h, got %h", $time, e, a);
      end
   endtask
   // one check for each kind of result
   task automatic check_status(input logic [15:0] e);
      compare(e, {3'h0, status});
   endtask
   task automatic check_setpoint(input logic [15:0] e);
      compare(e, {8'h00, setpoint});
   endtask
   task automatic check_pulses(input logic [15:0] e);
      compare(e, pulses[15:0]);
   endtask
   // wait, queue a note, then let the monitor look
   task automatic expect_after(input int w, input logic [1:0] k, input logic [15:0] v);
      repeat (w) @(negedge clk_in);
      notes.push_back({k, v});
      look <= 1'b1;
      @(negedge clk_in);
      look <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // refresh pulse counter
   always @(posedge clk_in) if (refresh === 1'b1) pulses++;
   // monitor: oldest note against the outputs
   always @(negedge clk_in) begin
      while (look && notes.size() > 0) begin
         n = notes.pop_front();
         if (n[17:16] == 2'h0) check_status(n[15:0]);
         else if (n[17:16] == 2'h1) check_setpoint(n[15:0]);
         else check_pulses(n[15:0]);
      end
   end
   // hang guard
   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      expect_after(1, 2'h0, 16'h0000);
      ready = 1'b1;
      adp = 1'b1;
      for (int i = 0; i < 4; i++) begin
         mv = lv[i];
         {over, at_sp, rail} = 3'($random(seed));
         expect_after(i == 0 ? 220 : 2, 2'h0, st(1'b0, i == 3, FS_ANALOG_MV));
         expect_after(1, 2'h1, 16'h0000);
      end
      pwm_en = 1'b1;
      hi = 16'd200;
      expect_after(1000, 2'h0, st(1'b0, 1'b1, FS_ANALOG_MV));
      $display("test analog done");
      pwm_en = 1'b0;
      pulses = 0;
      expect_after(499, 2'h2, 16'(500 / REF));
      adp = 1'b0;
      repeat (5) @(negedge clk_in);
      pulses = 0;
      expect_after(499, 2'h2, 16'h0000);
      adp = 1'b1;
      $display("test refresh done");
      ready = 1'b0;
      repeat (5) @(negedge clk_in);
      ready = 1'b1;
      pwm_en = 1'b1;
      for (int i = 0; i < 5; i++) begin
         hi = (i == 4) ? 16'd398 : 16'd40 + 16'($random(seed) & 255);
         {over, at_sp, rail} = 3'($random(seed));
         c = int'(hi) * 255000 / (int'(per) * FS_DUTY_PERMILLE);
         if (c > 255) c = 255;
         expect_after(i == 0 ? 1500 : 1000, 2'h1, 16'(c));
         expect_after(1, 2'h0, st(1'b1, 1'b1, FS_PWM_MV));
      end
      $display("test pwm done");
      pwm_en = 1'b0;
      lvl = 1'b0;
      expect_after(2500, 2'h0, st(1'b1, 1'b0, FS_PWM_MV));
      expect_after(1, 2'h1, 16'h0000);
      lvl = 1'b1;
      expect_after(2500, 2'h1, 16'h00ff);
      $display("test flat pin done");
      repeat (2) @(negedge clk_in);
      wrap_up();
   end
endmodule

// ==== src/csd_pkg.sv ====
package csd_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned DETECT_MS       = 20;
   localparam int unsigned DETECT_CYC      = DETECT_MS * (CLK_HZ / 1000);
   localparam int unsigned REFRESH_MS      = 5;
   localparam int unsigned REFRESH_CYC     = REFRESH_MS * (CLK_HZ / 1000);
   // pwm frequency limits
   localparam int unsigned PWM_FMIN_HZ     = 128;
   localparam int unsigned PWM_FMAX_HZ     = 500_000;
   localparam int unsigned PWM_MAXPER_CYC  = CLK_HZ / PWM_FMIN_HZ;
   localparam int unsigned PWM_MINPER_CYC  = (CLK_HZ + PWM_FMAX_HZ - 1) / PWM_FMAX_HZ;
   // full-scale duty in tenths of a percent
   localparam int unsigned FS_DUTY_PERMILLE = 995;
   // analog thresholds, setting level in millivolts
   localparam logic [11:0] SHDN_MV         = 12'h01a;
   localparam logic [11:0] ENABLE_MV       = 12'h02d;
   localparam logic [7:0]  FS_ANALOG_MV    = 8'h50;
   localparam logic [7:0]  FS_PWM_MV       = 8'h3c;
   localparam logic [7:0]  CODE_RST        = 8'h00;
   localparam logic [7:0]  CODE_MAX        = 8'hff;

   typedef enum logic [1:0] {
      CSD_WAIT   = 2'b00,
      CSD_DETECT = 2'b01,
      CSD_ANALOG = 2'b10,
      CSD_PWM    = 2'b11
   } csd_mode_t;

   typedef enum logic [1:0] {
      CSD_LOOP_CURRENT = 2'b00,
      CSD_LOOP_VOLTAGE = 2'b01,
      CSD_LOOP_INPUT   = 2'b10
   } csd_loop_t;

   // status bundle reported to the converter
   typedef struct packed {
      logic      pwm_mode;
      logic      charge_enable;
      logic      default_voltage;
      csd_loop_t loop_sel;
      logic [7:0] full_scale_mv;
   } csd_status_t;
endpackage

// ==== src/csd_pwm_meter.sv ====
`timescale 1ns/10ps
// measures high time against period of the setting pwm signal
module csd_pwm_meter
   import csd_pkg::*;
#(
   parameter int unsigned MAXPER = PWM_MAXPER_CYC,
   parameter int unsigned MINPER = PWM_MINPER_CYC
) (
   // clock and control
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic       run_in,
   // synchronised setting level
   input  wire logic       level_in,
   // results
   output logic [7:0]      code_out,
   output logic            code_valid_out,
   output logic            zero_out
);
   localparam int W = $clog2(MAXPER + 2);
   localparam logic [W-1:0] MAXPER_W = W'(MAXPER);
   localparam logic [W-1:0] MINPER_W = W'(MINPER);
   // room for a high time times 255000 without overflow
   localparam int SW = W + 18;

   logic [W-1:0] per_q, per_d, hi_q, hi_d;
   logic         lvl_q, lvl_d;
   logic [7:0]   code_q, code_d;
   logic         val_q, val_d, zero_q, zero_d;
   logic [SW-1:0] scaled;
   logic [SW-1:0] fs_den;

   // next state of period counters and setpoint
   always_comb begin
      per_d  = per_q;
      hi_d   = hi_q;
      lvl_d  = level_in;
      code_d = code_q;
      val_d  = val_q;
      zero_d = zero_q;
      scaled = '0;
      fs_den = '0;
      if (!run_in) begin
         per_d  = '0;
         hi_d   = '0;
         code_d = CODE_RST; // forget the result of an earlier pwm session
         val_d  = 1'b0;
         zero_d = 1'b0;
      end else if (level_in && !lvl_q) begin
         // rising edge closes one period; a period without a high phase was partial [RULE_14]
         if (per_q >= MINPER_W && hi_q != '0) begin // [RULE_04]
            fs_den = SW'(per_q) * SW'(FS_DUTY_PERMILLE);
            scaled = (SW'(hi_q) * SW'(255_000)) / fs_den; // [RULE_03] [RULE_06]
            code_d = (scaled > SW'(CODE_MAX)) ? CODE_MAX : scaled[7:0]; // [RULE_14]
            val_d  = 1'b1;
            zero_d = 1'b0;
         end
         per_d = W'(1);
         hi_d  = W'(1);
      end else if (per_q >= MAXPER_W) begin
         // no edge in a slowest period: flat line, zero duty when low [RULE_05]
         per_d  = '0;
         hi_d   = '0;
         code_d = level_in ? CODE_MAX : CODE_RST;
         zero_d = !level_in;
         val_d  = level_in;
      end else begin
         per_d = per_q + W'(1);
         hi_d  = level_in ? hi_q + W'(1) : hi_q;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         per_q  <= '0;
         hi_q   <= '0;
         lvl_q  <= 1'b0;
         code_q <= CODE_RST;
         val_q  <= 1'b0;
         zero_q <= 1'b0;
      end else if (ce_in) begin
         per_q  <= per_d;
         hi_q   <= hi_d;
         lvl_q  <= lvl_d;
         code_q <= code_d;
         val_q  <= val_d;
         zero_q <= zero_d;
      end
   end

   assign code_out       = code_q;
   assign code_valid_out = val_q;
   assign zero_out       = zero_q;
endmodule

// ==== src/csd_top.sv ====
`timescale 1ns/10ps
// What this block does
// RULE_01 - no edge in 20 ms: analog mode
// RULE_02 - edge within 20 ms: pwm mode
// RULE_03 - duty becomes 8-bit equal-step setpoint
// RULE_04 - decode pwm from 128 Hz to 500 kHz
// RULE_05 - zero duty shuts charger down
// RULE_06 - 99.5 percent duty is 60 mV full scale
// RULE_07 - full scale 80 mV analog, 60 mV pwm
// RULE_08 - analog level below 26 mV shuts down
// RULE_09 - refresh pulse every 5 ms with adapter
// RULE_10 - no adapter, no refresh pulses
// RULE_11 - current, voltage, input loop priority select
// RULE_12 - adjust tied rail selects 4.2 V/cell
// RULE_13 - charge only above 45 mV or pwm
// RULE_14 - setpoint refreshed once per pwm period
// RULE_15 - mode held until next ready event
module csd_top
   import csd_pkg::*;
#(
   parameter int unsigned DETECT_CYCLES  = DETECT_CYC,
   parameter int unsigned REFRESH_CYCLES = REFRESH_CYC,
   parameter int unsigned PWM_MAX_PERIOD = PWM_MAXPER_CYC
) (
   // clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // charger state from analog side
   input  wire logic        charger_ready_in,
   input  wire logic        adapter_present_in,
   input  wire logic        battery_at_setpoint_in,
   input  wire logic        input_over_limit_in,
   input  wire logic        voltage_adjust_rail_in,
   // charge setting input: pin level and digitised analog level in mV
   input  wire logic        charge_setting_input_in,
   input  wire logic [11:0] setting_level_mv_in,
   // outputs
   output logic [7:0]       setpoint_out,
   output csd_status_t      status_out,
   output logic             boost_supply_refresh_out
);
   // counter widths
   localparam int DW = $clog2(DETECT_CYCLES + 1);
   localparam int RW = $clog2(REFRESH_CYCLES + 1);
   // last count of each timer
   localparam logic [DW-1:0] DET_LAST = DW'(DETECT_CYCLES - 1);
   localparam logic [RW-1:0] REF_LAST = RW'(REFRESH_CYCLES - 1);

   // mode detection state
   csd_mode_t     mode_q;
   csd_mode_t     mode_d;
   logic [DW-1:0] det_q;
   logic [DW-1:0] det_d;
   // refresh timer state
   logic [RW-1:0] ref_q;
   logic [RW-1:0] ref_d;
   logic          pulse_q;
   logic          pulse_d;
   // pin synchroniser, ready flop and settled setting level
   logic [2:0]    sync_q;
   logic [2:0]    sync_d;
   logic          rdy_q;
   logic          rdy_d;
   logic          filt_q;
   logic          filt_d;
   // registered outputs
   logic [7:0]    set_q;
   logic [7:0]    set_d;
   csd_status_t   st_q;
   csd_status_t   st_d;
   // meter results and derived strobes
   logic [7:0]    pwm_code;
   logic          pwm_valid;
   logic          pwm_zero;
   logic          edge_seen;
   logic          setting_lvl;

   // next values of the pin synchroniser, the ready flop and the settled level
   always_comb begin
      sync_d = {sync_q[1:0], charge_setting_input_in};
      rdy_d  = charger_ready_in;
      filt_d = filt_q;
      if (sync_q[1] == sync_q[2]) begin
         filt_d = sync_q[2]; // a change counts once stages 2 and 3 agree
      end
   end

   // three-stage synchroniser on the setting pin, which is not of this clock
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync_q <= 3'h0;
         rdy_q  <= 1'b0;
         filt_q <= 1'b0;
      end else if (ce_in) begin
         sync_q <= sync_d;
         rdy_q  <= rdy_d;
         filt_q <= filt_d;
      end
   end

   // settled level, and an edge once a new level has settled [RULE_02]
   assign setting_lvl = filt_q;
   assign edge_seen   = (sync_q[1] == sync_q[2]) && (sync_q[2] != filt_q);

   // duty cycle measurement, only run in pwm mode
   csd_pwm_meter #(
      .MAXPER (PWM_MAX_PERIOD),
      .MINPER (PWM_MINPER_CYC)
   ) u_meter (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .ce_in          (ce_in),
      .run_in         (mode_q == CSD_PWM),
      .level_in       (setting_lvl),
      .code_out       (pwm_code),
      .code_valid_out (pwm_valid),
      .zero_out       (pwm_zero)
   );

   // mode detection after charger ready
   always_comb begin
      mode_d = mode_q;
      det_d  = det_q;
      case (mode_q)
         CSD_WAIT: begin
            det_d = '0;
            if (rdy_q) mode_d = CSD_DETECT;
         end
         CSD_DETECT: begin
            if (!rdy_q) begin
               mode_d = CSD_WAIT;
            end else if (edge_seen) begin
               mode_d = CSD_PWM; // [RULE_02]
            end else if (det_q == DET_LAST) begin
               mode_d = CSD_ANALOG; // [RULE_01]
            end else begin
               det_d = det_q + DW'(1);
            end
         end
         default: begin
            if (!rdy_q) mode_d = CSD_WAIT; // held until ready drops [RULE_15]
         end
      endcase
   end

   // mode registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode_q <= CSD_WAIT;
         det_q  <= '0;
      end else if (ce_in) begin
         mode_q <= mode_d;
         det_q  <= det_d;
      end
   end

   // setpoint, enable, loop selection and full scale
   always_comb begin
      st_d  = '0;
      set_d = CODE_RST;
      st_d.default_voltage = voltage_adjust_rail_in; // [RULE_12]
      if (input_over_limit_in) begin
         st_d.loop_sel = CSD_LOOP_INPUT; // [RULE_11]
      end else if (battery_at_setpoint_in) begin
         st_d.loop_sel = CSD_LOOP_VOLTAGE; // [RULE_11]
      end else begin
         st_d.loop_sel = CSD_LOOP_CURRENT; // [RULE_11]
      end
      if (mode_q == CSD_PWM) begin
         st_d.pwm_mode      = 1'b1;
         st_d.full_scale_mv = FS_PWM_MV; // [RULE_07]
         set_d              = pwm_code; // [RULE_03]
         st_d.charge_enable = pwm_valid && !pwm_zero; // [RULE_05] [RULE_13]
      end else if (mode_q == CSD_ANALOG) begin
         st_d.full_scale_mv = FS_ANALOG_MV; // [RULE_07]
         st_d.charge_enable = (setting_level_mv_in > ENABLE_MV); // [RULE_13]
         if (setting_level_mv_in < SHDN_MV) begin
            st_d.charge_enable = 1'b0; // [RULE_08]
         end
      end
   end

   // refresh timer for boost supply charge pump
   always_comb begin
      ref_d   = ref_q;
      pulse_d = 1'b0;
      if (!adapter_present_in) begin
         ref_d = '0; // [RULE_10]
      end else if (ref_q == REF_LAST) begin
         ref_d   = '0;
         pulse_d = 1'b1; // [RULE_09]
      end else begin
         ref_d = ref_q + RW'(1);
      end
   end

   // refresh timer registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ref_q   <= '0;
         pulse_q <= 1'b0;
      end else if (ce_in) begin
         ref_q   <= ref_d;
         pulse_q <= pulse_d;
      end
   end

   // setpoint and status registers, so every output leaves a flip-flop
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         set_q <= CODE_RST;
         st_q  <= '0;
      end else if (ce_in) begin
         set_q <= set_d;
         st_q  <= st_d;
      end
   end

   // outputs straight from their registers
   assign setpoint_out             = set_q;
   assign status_out               = st_q;
   assign boost_supply_refresh_out = pulse_q;
endmodule
